// ### pkg/spp_cfg.svh
// Constants for the six pin port: offsets, field positions, reset values
//------------------------------------------------------------------------------
//------------------------------------------------------------------------------
`ifndef SPP_CFG_SVH
`define SPP_CFG_SVH

//------------------------------------------------------------------------------
// Register indices (byte address is four times the index)
//------------------------------------------------------------------------------
`define SPP_IDX_PORT      14'h0005
`define SPP_IDX_DIR       14'h0085
`define SPP_IDX_PULLUP    14'h0095
`define SPP_IDX_CHG_EN    14'h0096
`define SPP_IDX_OPTION    14'h0081
`define SPP_IDX_INTCTL    14'h000B
`define SPP_IDX_ANALOG    14'h009F
`define SPP_IDX_CONFIG    14'h2007

//------------------------------------------------------------------------------
// Field positions
//------------------------------------------------------------------------------
`define SPP_IN_ONLY_BIT   3
`define SPP_XTAL_HI       5
`define SPP_XTAL_LO       4
`define SPP_OPT_GPU_BIT   7
`define SPP_IC_GIE_BIT    7
`define SPP_IC_PIE_BIT    3
`define SPP_IC_FLAG_BIT   0
`define SPP_CFG_MASTER_CLEAR_PIN_BIT  5
`define SPP_CFG_OSC_HI    2
`define SPP_CFG_OSC_LO    0
`define SPP_ANA_HI        3
`define SPP_WR_LANE       0

//------------------------------------------------------------------------------
// Reset values
//------------------------------------------------------------------------------
`define SPP_RST_PINS      6'h3F
`define SPP_RST_PULLUP    6'h37
`define SPP_RST_ZERO6     6'h00
`define SPP_RST_OPTION    8'hFF
`define SPP_RST_ANALOG    4'hF
`define SPP_RST_CONFIG    8'h20
`define SPP_PIN3_MASK     6'h08
`define SPP_XTAL_MASK     6'h30
`define SPP_ZERO32        32'h0000_0000

`endif

// ### pkg/spp_chg_if.sv
// Carrier between the port core and its change detector
`timescale 1ns/1ps
interface spp_chg_if;
	spp_pkg::spp_pins_type pins;       // Synchronised pin levels
	spp_pkg::spp_pins_type enable;     // Per-pin change enables
	logic                  capture;    // Refresh the snapshot
	logic                  mismatch;   // Any enabled pin differs

	modport core (output pins, output enable, output capture, input mismatch);
	modport det  (input pins, input enable, input capture, output mismatch);
endinterface

// ### pkg/spp_pkg.sv
// Types shared by the six pin port modules
package spp_pkg;

	// One bit for each port pin
	typedef logic [5:0] spp_pins_type;

	// Oscillator selection field of the configuration word
	typedef enum logic [2:0] {
		SPP_OSC_LOW_POWER  = 3'h0,
		SPP_OSC_MEDIUM     = 3'h1,
		SPP_OSC_HIGH_SPEED = 3'h2,
		SPP_OSC_EXT_RC     = 3'h3,
		SPP_OSC_INT_IO     = 3'h4,
		SPP_OSC_INT_CLK    = 3'h5,
		SPP_OSC_RC_IO      = 3'h6,
		SPP_OSC_RC_CLK     = 3'h7
	} spp_osc_type;

endpackage

// ### src/spp_change_detect.sv
// Change detector: snapshot of last port access and mismatch compare
`timescale 1ns/1ps
`include "spp_cfg.svh"
module spp_change_detect (
	input  wire logic pclk,          // Core clock
	input  wire logic presetn,       // Power-on reset, active low
	spp_chg_if.det    chg            // Pins, enables and capture strobe
);

	spp_pkg::spp_pins_type snapshot;

	//--------------------------------------------------------------------
	// Snapshot latch
	//--------------------------------------------------------------------
	// Only power-on clears it; warm resets never reach this module
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			snapshot <= `SPP_RST_ZERO6;
		end else if (chg.capture) begin
			snapshot <= chg.pins;
		end
	end

	// An enabled pin moving in the capture cycle still raises mismatch as the snapshot takes it
	assign chg.mismatch = |((chg.pins ^ snapshot) & chg.enable);

endmodule

// ### src/spp_port.sv
// Six pin general purpose port with pull-ups and change detection
`timescale 1ns/1ps
`include "spp_cfg.svh"
module spp_port (
	input  wire logic        pclk,            // Core clock, 40 MHz
	input  wire logic        presetn,         // Power-on reset, active low
	input  wire logic        warm_reset,      // Master clear or brown-out reset
	input  wire logic        psel,            // APB select
	input  wire logic        penable,         // APB access phase
	input  wire logic        pwrite,          // APB direction
	input  wire logic [15:0] paddr,           // APB byte address
	input  wire logic [31:0] pwdata,          // APB write data
	input  wire logic [3:0]  pstrb,           // APB byte strobes
	output logic      [31:0] prdata,          // APB read data
	output logic             pready,          // APB ready
	output logic             pslverr,         // APB error on unmapped address
	input  wire logic [5:0]  pin_in,          // Pin levels from pads
	output logic      [5:0]  pin_out,         // Pin output values
	output logic      [5:0]  pin_oe_n,        // Pin driver enable, low drives
	output logic      [5:0]  pullup_on,       // Weak pull-up active
	input  wire logic [5:0]  periph_own,      // Peripheral owns the pin
	input  wire logic [5:0]  periph_out,      // Peripheral output value
	input  wire logic [5:0]  periph_drive,    // Peripheral drives the pin
	output logic             irq_request,     // Port change interrupt
	output logic             wake_request     // Port change wake from sleep
);

	//--------------------------------------------------------------------
	// Declarations
	//--------------------------------------------------------------------
	spp_pkg::spp_pins_type pin_meta;
	spp_pkg::spp_pins_type pin_sync;
	spp_pkg::spp_pins_type out_latch;
	spp_pkg::spp_pins_type dir_bits;
	spp_pkg::spp_pins_type pullup_enable_bits;
	spp_pkg::spp_pins_type change_detect_enable;
	logic            [7:0] option_reg;
	logic                  global_interrupt_enable;
	logic                  port_change_enable;
	logic                  port_change_flag;
	logic            [3:0] analog_select_reg;
	logic            [7:0] config_word;

	logic                  setup_phase;
	logic                  access_done;
	logic                  wr_done;
	logic                  rd_done;
	logic           [13:0] reg_index;
	logic                  hit_port;
	logic                  hit_dir;
	logic                  hit_pullup;
	logic                  hit_chg_en;
	logic                  hit_option;
	logic                  hit_intctl;
	logic                  hit_analog;
	logic                  hit_config;
	logic                  hit_any;
	logic                  crystal_mode;
	logic                  master_clear_select;
	logic                  global_pullup_control;
	spp_pkg::spp_osc_type  osc_mode;
	spp_pkg::spp_pins_type analog_mask;
	spp_pkg::spp_pins_type port_read;
	spp_pkg::spp_pins_type dir_read;
	spp_pkg::spp_pins_type pullup_read;
	spp_pkg::spp_pins_type chg_read;
	spp_pkg::spp_pins_type dir_eff;
	spp_pkg::spp_pins_type next_pin_out;
	spp_pkg::spp_pins_type next_pin_oe_n;
	spp_pkg::spp_pins_type next_pullup_on;
	spp_pkg::spp_pins_type next_latch;
	logic           [31:0] next_prdata;

	spp_chg_if chg ();

	//--------------------------------------------------------------------
	// Pin synchroniser
	//--------------------------------------------------------------------
	// Pads are asynchronous; only pin_sync feeds any logic
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta <= `SPP_RST_ZERO6;
			pin_sync <= `SPP_RST_ZERO6;
		end else begin
			pin_meta <= pin_in;
			pin_sync <= pin_meta;
		end
	end

	//--------------------------------------------------------------------
	// APB decode
	//--------------------------------------------------------------------
	// Fixed one wait-free access: pready rises for the cycle after setup
	assign setup_phase = psel & ~penable;
	assign access_done = psel & penable & pready;
	assign wr_done     = access_done & pwrite;
	assign rd_done     = access_done & ~pwrite;
	assign reg_index   = paddr[15:2];
	assign hit_port    = (reg_index == `SPP_IDX_PORT);
	assign hit_dir     = (reg_index == `SPP_IDX_DIR);
	assign hit_pullup  = (reg_index == `SPP_IDX_PULLUP);
	assign hit_chg_en  = (reg_index == `SPP_IDX_CHG_EN);
	assign hit_option  = (reg_index == `SPP_IDX_OPTION);
	assign hit_intctl  = (reg_index == `SPP_IDX_INTCTL);
	assign hit_analog  = (reg_index == `SPP_IDX_ANALOG);
	assign hit_config  = (reg_index == `SPP_IDX_CONFIG);
	assign hit_any     = hit_port | hit_dir | hit_pullup | hit_chg_en | hit_option | hit_intctl | hit_analog
		| hit_config;

	//--------------------------------------------------------------------
	// Configuration decode
	//--------------------------------------------------------------------
	assign osc_mode              = spp_pkg::spp_osc_type'(config_word[`SPP_CFG_OSC_HI:`SPP_CFG_OSC_LO]);
	assign crystal_mode          = (osc_mode == spp_pkg::SPP_OSC_LOW_POWER) | (osc_mode == spp_pkg::SPP_OSC_MEDIUM)
		| (osc_mode == spp_pkg::SPP_OSC_HIGH_SPEED);
	assign master_clear_select   = config_word[`SPP_CFG_MASTER_CLEAR_PIN_BIT];
	// Option bit set means pull-ups globally off
	assign global_pullup_control = ~option_reg[`SPP_OPT_GPU_BIT];

	// Analog selects cover pins 0, 1, 2 and 4
	assign analog_mask = {1'b0, analog_select_reg[`SPP_ANA_HI], 1'b0, analog_select_reg[2:0]};

	//--------------------------------------------------------------------
	// Read views of the registers
	//--------------------------------------------------------------------
	// Port shows pin levels, not the latch; analog and master clear read zero
	assign port_read = pin_sync & ~analog_mask
		& ~(master_clear_select ? `SPP_PIN3_MASK : `SPP_RST_ZERO6);
	assign dir_read    = dir_bits | `SPP_PIN3_MASK
		| (crystal_mode ? `SPP_XTAL_MASK : `SPP_RST_ZERO6);
	assign pullup_read = (pullup_enable_bits & ~`SPP_PIN3_MASK)
		| (crystal_mode ? `SPP_XTAL_MASK : `SPP_RST_ZERO6);
	assign chg_read    = change_detect_enable | (crystal_mode ? `SPP_XTAL_MASK : `SPP_RST_ZERO6);

	// Read data mux, sampled in the setup cycle
	always_comb begin
		next_prdata = `SPP_ZERO32;
		if (hit_port) begin
			next_prdata[5:0] = port_read;
		end else if (hit_dir) begin
			next_prdata[5:0] = dir_read;
		end else if (hit_pullup) begin
			next_prdata[5:0] = pullup_read;
		end else if (hit_chg_en) begin
			next_prdata[5:0] = chg_read;
		end else if (hit_option) begin
			next_prdata[7:0] = option_reg;
		end else if (hit_intctl) begin
			next_prdata[`SPP_IC_GIE_BIT]  = global_interrupt_enable;
			next_prdata[`SPP_IC_PIE_BIT]  = port_change_enable;
			next_prdata[`SPP_IC_FLAG_BIT] = port_change_flag;
		end else if (hit_analog) begin
			next_prdata[3:0] = analog_select_reg;
		end else if (hit_config) begin
			next_prdata[7:0] = config_word;
		end
	end

	//--------------------------------------------------------------------
	// APB answer
	//--------------------------------------------------------------------
	// Registered answer keeps every bus output straight from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= `SPP_ZERO32;
		end else begin
			pready  <= setup_phase;
			pslverr <= setup_phase & ~hit_any;
			if (setup_phase && !pwrite) begin
				prdata <= next_prdata;
			end
		end
	end

	//--------------------------------------------------------------------
	// Output latch
	//--------------------------------------------------------------------
	// A lane left unstrobed rewrites the pins it reads back, as on the core
	assign next_latch = pstrb[`SPP_WR_LANE] ? pwdata[5:0] : port_read;

	// Warm resets leave the latch alone; only power-on clears it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_latch <= `SPP_RST_ZERO6;
		end else if (wr_done && hit_port) begin
			out_latch <= next_latch;
		end
	end

	//--------------------------------------------------------------------
	// Direction register
	//--------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dir_bits <= `SPP_RST_PINS;
		end else if (warm_reset) begin
			dir_bits <= `SPP_RST_PINS;
		end else if (wr_done && hit_dir && pstrb[`SPP_WR_LANE]) begin
			dir_bits <= pwdata[5:0] | `SPP_PIN3_MASK;
		end
	end

	//--------------------------------------------------------------------
	// Pull-up enable register
	//--------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pullup_enable_bits <= `SPP_RST_PULLUP;
		end else if (warm_reset) begin
			pullup_enable_bits <= `SPP_RST_PULLUP;
		end else if (wr_done && hit_pullup && pstrb[`SPP_WR_LANE]) begin
			pullup_enable_bits <= pwdata[5:0] & ~`SPP_PIN3_MASK;
		end
	end

	//--------------------------------------------------------------------
	// Change enable register
	//--------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			change_detect_enable <= `SPP_RST_ZERO6;
		end else if (warm_reset) begin
			change_detect_enable <= `SPP_RST_ZERO6;
		end else if (wr_done && hit_chg_en && pstrb[`SPP_WR_LANE]) begin
			change_detect_enable <= pwdata[5:0];
		end
	end

	//--------------------------------------------------------------------
	// Option, analog select and configuration registers
	//--------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			option_reg <= `SPP_RST_OPTION;
		end else if (warm_reset) begin
			option_reg <= `SPP_RST_OPTION;
		end else if (wr_done && hit_option && pstrb[`SPP_WR_LANE]) begin
			option_reg <= pwdata[7:0];
		end
	end

	// Analog pins keep their direction bit; software must leave it set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			analog_select_reg <= `SPP_RST_ANALOG;
		end else if (warm_reset) begin
			analog_select_reg <= `SPP_RST_ANALOG;
		end else if (wr_done && hit_analog && pstrb[`SPP_WR_LANE]) begin
			analog_select_reg <= pwdata[3:0];
		end
	end

	// Configuration word survives warm resets like nonvolatile fuses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			config_word <= `SPP_RST_CONFIG;
		end else if (wr_done && hit_config && pstrb[`SPP_WR_LANE]) begin
			config_word <= pwdata[7:0];
		end
	end

	//--------------------------------------------------------------------
	// Interrupt control and port change flag
	//--------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			global_interrupt_enable <= 1'b0;
			port_change_enable      <= 1'b0;
		end else if (warm_reset) begin
			global_interrupt_enable <= 1'b0;
			port_change_enable      <= 1'b0;
		end else if (wr_done && hit_intctl && pstrb[`SPP_WR_LANE]) begin
			global_interrupt_enable <= pwdata[`SPP_IC_GIE_BIT];
			port_change_enable      <= pwdata[`SPP_IC_PIE_BIT];
		end
	end

	// Mismatch wins over a clear, so a handler that skips the port read loops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_change_flag <= 1'b0;
		end else if (chg.mismatch) begin
			port_change_flag <= 1'b1;
		end else if (warm_reset) begin
			port_change_flag <= 1'b0;
		end else if (wr_done && hit_intctl && pstrb[`SPP_WR_LANE]) begin
			port_change_flag <= pwdata[`SPP_IC_FLAG_BIT];
		end
	end

	//--------------------------------------------------------------------
	// Change detector hookup
	//--------------------------------------------------------------------
	// Any completed port access, read or write, refreshes the snapshot
	assign chg.pins    = pin_sync;
	assign chg.enable  = change_detect_enable;
	assign chg.capture = access_done & hit_port;

	spp_change_detect u_detect (
		.pclk    (pclk),
		.presetn (presetn),
		.chg     (chg)
	);

	//--------------------------------------------------------------------
	// Pin drivers and pull-ups
	//--------------------------------------------------------------------
	// The input only pin never drives; crystal pins drive only when a peripheral owns them
	assign dir_eff = dir_bits | `SPP_PIN3_MASK | (crystal_mode ? `SPP_XTAL_MASK : `SPP_RST_ZERO6);

	// Peripheral ownership overrides the port driver per pin, except on the input only pin
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			if (periph_own[i] && i != `SPP_IN_ONLY_BIT) begin
				next_pin_out[i]  = periph_out[i];
				next_pin_oe_n[i] = ~periph_drive[i];
			end else begin
				next_pin_out[i]  = out_latch[i];
				next_pin_oe_n[i] = dir_eff[i];
			end
		end
	end

	// Pull-up needs its enable, input direction and the global permit; pin three follows master clear alone
	always_comb begin
		next_pullup_on = pullup_enable_bits & dir_eff & ~`SPP_PIN3_MASK
			& {6{global_pullup_control}};
		next_pullup_on[`SPP_IN_ONLY_BIT] = master_clear_select;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_out   <= `SPP_RST_ZERO6;
			pin_oe_n  <= `SPP_RST_PINS;
			pullup_on <= `SPP_RST_ZERO6;
		end else begin
			pin_out   <= next_pin_out;
			pin_oe_n  <= next_pin_oe_n;
			pullup_on <= next_pullup_on;
		end
	end

	//--------------------------------------------------------------------
	// Interrupt and wake outputs
	//--------------------------------------------------------------------
	// Wake ignores the global enable; the interrupt needs it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_request  <= 1'b0;
			wake_request <= 1'b0;
		end else begin
			irq_request  <= port_change_flag & port_change_enable & global_interrupt_enable;
			wake_request <= port_change_flag & port_change_enable;
		end
	end

endmodule

// ### test/spp_pads.sv
// Pad model: outside drivers, weak pull-ups and floating pins
`timescale 1ns/1ps
module spp_pads (
	input  wire logic       pclk,      // Clock
	input  wire logic [5:0] pin_out,   // Port values
	input  wire logic [5:0] pin_oe_n,  // Port drives when low
	input  wire logic [5:0] pullup_on, // Weak pull-up
	input  wire logic [5:0] ext_en,    // Outside drives
	input  wire logic [5:0] ext_val,   // Outside value
	output logic      [5:0] pin_level  // Pad level
);
	logic [5:0] float_pat;
	// Undriven pins wander so that a missing pull-up cannot hide
	always_ff @(posedge pclk) float_pat <= (float_pat === 6'h15) ? 6'h2A : 6'h15;
	// Port driver beats the outside circuit, pull-up beats a float
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			if (!pin_oe_n[i]) pin_level[i] = pin_out[i];
			else if (ext_en[i]) pin_level[i] = ext_val[i];
			else pin_level[i] = pullup_on[i] | float_pat[i];
		end
	end
endmodule

// ### test/spp_port_asserts.sv
// Concurrent checks on the ports of the six pin port
`timescale 1ns/1ps
module spp_port_asserts (
	input wire logic        pclk,        // Clock
	input wire logic        presetn,     // Reset
	input wire logic        warm_reset,  // Warm reset
	input wire logic        psel,        // Select
	input wire logic        penable,     // Access
	input wire logic        pwrite,      // Write
	input wire logic [31:0] prdata,      // Read data
	input wire logic        pready,      // Ready
	input wire logic        pslverr,     // Error
	input wire logic [5:0]  pin_oe_n,    // Drive off
	input wire logic [5:0]  pullup_on,   // Pull-ups
	input wire logic        irq_request, // Interrupt
	input wire logic        wake_request // Wake
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Flag up two cycles with no write or warm reset that could clear it
	sequence flag_alone;
		(wake_request && !(psel && penable && pwrite) && !warm_reset) [*2];
	endsequence
	// Bus answer timing; read data only moves after a setup edge
	a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no pready");
	a_err_with_ready: assert property (pslverr |-> pready) else $error("lone pslverr");
	a_rdata_holds: assert property (!(psel && !penable) |=> $stable(prdata)) else $error("prdata moved");
	// Pad drivers and pull-ups
	a_pin3_input: assert property (pin_oe_n[3]) else $error("pin three driven");
	a_pull_out_off: assert property ((pullup_on & ~pin_oe_n) == 6'h00) else $error("pull-up on output");
	a_warm_dir_in: assert property (warm_reset && !(psel && penable && pwrite) |=> ##1 pin_oe_n == 6'h3F)
		else $error("warm reset left drivers on");
	// Change flag
	a_irq_needs_wake: assert property (irq_request |-> wake_request) else $error("irq without wake");
	a_flag_persists: assert property (flag_alone |=> wake_request) else $error("flag dropped");
endmodule
bind spp_port spp_port_asserts spp_port_asserts_i (.pclk(pclk), .presetn(presetn), .warm_reset(warm_reset),
	.psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.pin_oe_n(pin_oe_n), .pullup_on(pullup_on), .irq_request(irq_request), .wake_request(wake_request));

// ### test/tb_spp_port.sv
// Self-checking bench for the six pin port
`timescale 1ns/1ps
`include "spp_cfg.svh"
module tb_spp_port;
	logic        pclk, presetn, warm_reset, psel, penable, pwrite, pready, pslverr, irq_request, wake_request, g, err;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  pstrb;
	logic [7:0]  rdv;
	logic [5:0]  pin_level, pin_out, pin_oe_n, pullup_on, ext_en, ext_val, d, v, w;
	logic [5:0]  periph_own, periph_out, periph_drive;
	int          bad_count, checks_done, cycles;
	spp_port spp_port_i (.pclk(pclk), .presetn(presetn), .warm_reset(warm_reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pin_in(pin_level), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pullup_on(pullup_on),
		.periph_own(periph_own), .periph_out(periph_out), .periph_drive(periph_drive), .irq_request(irq_request),
		.wake_request(wake_request));
	spp_pads spp_pads_i (.pclk(pclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pullup_on(pullup_on),
		.ext_en(ext_en), .ext_val(ext_val), .pin_level(pin_level));
	// Clock and a hang limit well past the expected run
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 8000) begin
			bad_count++;
			finish_test();
		end
	end
	task automatic finish_test();
		if (bad_count == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// One transfer; the request stands until pready is sampled high
	task automatic apb(input logic wr, input logic [13:0] ix, input logic [7:0] wd, input logic [3:0] st = 4'h1);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, wr, ix, 2'b00, 24'h00_0000, wd, st};
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rdv = prdata[7:0];
		err = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task automatic rchk(input string nm, input logic [13:0] ix, input logic [7:0] exp);
		apb(1'b0, ix, 8'h00);
		chk(nm, rdv, exp);
	endtask
	initial begin
		{presetn, warm_reset, psel, penable, pwrite, paddr, pwdata, pstrb, ext_en, ext_val} = '0;
		{periph_own, periph_out, periph_drive} = '0;
		void'($urandom(32'h9dac_4510));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values and an unmapped place
		rchk("dir", `SPP_IDX_DIR, 8'h3F);
		rchk("pu", `SPP_IDX_PULLUP, 8'h37);
		// Reset configuration is a crystal mode, so enables 5:4 read as one
		rchk("ioc", `SPP_IDX_CHG_EN, 8'h30);
		rchk("opt", `SPP_IDX_OPTION, 8'hFF);
		chk("pullon", 8'(pullup_on), 8'h08);
		rchk("hole", 14'h0001, 8'h00);
		chk("slverr", 8'(err), 8'h01);
		// Every crystal mode keeps pins 5:4 as inputs
		for (int m = 0; m < 3; m++) begin
			apb(1'b1, `SPP_IDX_CONFIG, 8'(m));
			apb(1'b1, `SPP_IDX_DIR, 8'h00);
			apb(1'b1, `SPP_IDX_PULLUP, 8'h00);
			rchk("xdir", `SPP_IDX_DIR, 8'h38);
			rchk("xpu", `SPP_IDX_PULLUP, 8'h30);
		end
		apb(1'b1, `SPP_IDX_CONFIG, 8'h04);
		apb(1'b1, `SPP_IDX_ANALOG, 8'h00);
		// Random direction, latch, pull-up and global control
		for (int k = 0; k < 24; k++) begin
			{g, d, v, w} = 19'($urandom());
			ext_val <= 6'($urandom());
			ext_en <= d | 6'h08;
			apb(1'b1, `SPP_IDX_OPTION, {g, 7'h7F});
			apb(1'b1, `SPP_IDX_PORT, 8'(v));
			apb(1'b1, `SPP_IDX_DIR, 8'(d));
			apb(1'b1, `SPP_IDX_PULLUP, 8'(w));
			repeat (3) @(posedge pclk);
			chk("oe", 8'(pin_oe_n), 8'(d | 6'h08));
			chk("out", 8'(pin_out & ~pin_oe_n), 8'(v & ~d & 6'h37));
			chk("pullon", 8'(pullup_on), 8'(g ? 6'h00 : w & d & 6'h37));
			rchk("port", `SPP_IDX_PORT, 8'((v & ~d & 6'h37) | (ext_val & (d | 6'h08))));
		end
		// A write with the data lane off stores what the pins read
		ext_en <= 6'h3F;
		ext_val <= 6'h2A;
		apb(1'b1, `SPP_IDX_DIR, 8'h3F);
		repeat (3) @(posedge pclk);
		apb(1'b1, `SPP_IDX_PORT, 8'h15, 4'h0);
		ext_en <= 6'h37;
		apb(1'b1, `SPP_IDX_DIR, 8'h00);
		repeat (3) @(posedge pclk);
		chk("rmw", 8'(pin_out & ~pin_oe_n), 8'h22);
		// Each enable watches its own pin only
		ext_en <= 6'h3F;
		apb(1'b1, `SPP_IDX_DIR, 8'h3F);
		for (int i = 0; i < 6; i++) begin
			apb(1'b1, `SPP_IDX_CHG_EN, 8'(6'h01 << i));
			apb(1'b0, `SPP_IDX_PORT, 8'h00);
			apb(1'b1, `SPP_IDX_INTCTL, 8'h08);
			ext_val <= ext_val ^ ~(6'h01 << i);
			repeat (6) @(posedge pclk);
			chk("quiet", 8'(wake_request), 8'h00);
			ext_val <= ext_val ^ (6'h01 << i);
			repeat (6) @(posedge pclk);
			chk("wake", 8'(wake_request), 8'h01);
			chk("irq", 8'(irq_request), 8'h00);
		end
		// A clear loses to a standing mismatch; port access first
		apb(1'b1, `SPP_IDX_INTCTL, 8'h88);
		repeat (3) @(posedge pclk);
		chk("held", 8'({irq_request, wake_request}), 8'h03);
		ext_val <= 6'h3F;
		apb(1'b0, `SPP_IDX_PORT, 8'h00);
		apb(1'b1, `SPP_IDX_INTCTL, 8'h88);
		repeat (3) @(posedge pclk);
		chk("clear", 8'(wake_request), 8'h00);
		// Analog pins read zero; the snapshot outlives a warm reset
		apb(1'b1, `SPP_IDX_ANALOG, 8'h0F);
		rchk("analog", `SPP_IDX_PORT, 8'h28);
		warm_reset <= 1'b1;
		@(posedge pclk);
		warm_reset <= 1'b0;
		ext_val <= 6'h00;
		apb(1'b1, `SPP_IDX_CHG_EN, 8'h20);
		apb(1'b1, `SPP_IDX_INTCTL, 8'h08);
		repeat (4) @(posedge pclk);
		chk("warm", 8'(wake_request), 8'h01);
		// Master clear owns pin three: pulled up, reads zero
		ext_val <= 6'h3F;
		apb(1'b1, `SPP_IDX_CONFIG, 8'h24);
		repeat (3) @(posedge pclk);
		chk("mclrpu", 8'(pullup_on), 8'h08);
		rchk("master_clear_pin", `SPP_IDX_PORT, 8'h20);
		// A peripheral takes pins 0, 1 and 3; pin three still never drives
		{periph_own, periph_out, periph_drive} <= {6'h0B, 6'h3F, 6'h09};
		repeat (3) @(posedge pclk);
		chk("own", 8'(pin_oe_n), 8'h3E);
		chk("ownout", 8'(pin_out & ~pin_oe_n), 8'h01);
		finish_test();
	end
endmodule
